/* File: iack_chain_pkg.sv */
// Constants and types shared by the acknowledge daisy-chain channel.
// Assumes a 100 MHz system clock and a classic Wishbone register bus.
package iack_chain_pkg;

  // Interrupt types, index 0 is the highest priority
  localparam int NUM_TYPES = 6;
  localparam logic [2:0] TYPE_RX_STATUS = 3'h0;
  localparam logic [2:0] TYPE_RX_DATA   = 3'h1;
  localparam logic [2:0] TYPE_TX_STATUS = 3'h2;
  localparam logic [2:0] TYPE_TX_DATA   = 3'h3;
  localparam logic [2:0] TYPE_IO_PIN    = 3'h4;
  localparam logic [2:0] TYPE_MISC      = 3'h5;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_PEND_CLR = 8'h08;
  localparam logic [7:0] OFS_IUS_CLR  = 8'h0C;
  localparam logic [7:0] OFS_PEND_SET = 8'h10;

  // Control register field positions
  localparam int CTRL_TEN_LSB   = 0;
  localparam int CTRL_MIE       = 8;
  localparam int CTRL_NV        = 9;
  localparam int CTRL_DLC       = 10;
  localparam int CTRL_DPULSE    = 11;
  localparam int CTRL_MUXED     = 12;
  localparam int CTRL_RDY_MODE  = 13;
  localparam int CTRL_VBASE_LSB = 16;

  // Status register field positions
  localparam int STAT_PEND_LSB  = 0;
  localparam int STAT_IUS_LSB   = 8;
  localparam int STAT_DP_SECOND = 16;
  localparam int STAT_IACK_CY   = 17;

  // Reset values
  localparam logic [7:0] VBASE_RST = 8'h00;

  // Pin index inside the synchroniser vectors
  localparam int PIN_SIACK = 0;
  localparam int PIN_PIACK = 1;
  localparam int PIN_AS    = 2;
  localparam int PIN_DS    = 3;
  localparam int PIN_RD    = 4;
  localparam int PIN_RW    = 5;
  localparam int PIN_CEI   = 6;
  localparam int NUM_PINS  = 7;

  // Response timing
  localparam int CLK_MHZ         = 100;
  localparam int WAIT_HOLD_NS    = 40;
  localparam int READ_RDY_NS     = 30;
  localparam int IACK_RDY_NS     = 60;
  localparam int WAIT_HOLD_CYC   = (WAIT_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_RDY_CYC    = (READ_RDY_NS * CLK_MHZ + 999) / 1000;
  localparam int IACK_RDY_CYC    = (IACK_RDY_NS * CLK_MHZ + 999) / 1000;

  // Acknowledge sequence phases
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_FROZEN,
    PH_RESPOND,
    PH_IGNORE
  } ph_e;

endpackage

/* File: iack_chain.sv */
// Acknowledge daisy-chain logic of one serial channel, with its registers.
// Assumes bus pins arrive asynchronously and a Wishbone master on clk_i.
//
// Overview of operation
// - Separate address and data: falling strobed_iack_n freezes state.
// - Frozen and requesting: chain_enable_out forced low, priority resolved.
// - Strobe, chain in high, request: set under-service, vector, wait.
// - Chain in low or no request at strobe fall: cycle ignored.
// - Single pulse mode: one pulsed_iack_n pulse replaces the strobe.
// - Single pulse: sample chain in at pulse fall, then vector and wait.
// - Single pulse: no response if chain in low or nothing requested.
// - Double pulse: two pulses form one acknowledge, strobes stay high.
// - Double pulse: flag tells pulses apart; first freezes, resolves.
// - Second pulse with chain in and request: under-service, vector, wait.
// - Second pulse: no response if chain in low or nothing requested.
// - Muxed: strobed_iack_n low at address strobe rise, address ignored.
// - Non-multiplexed: each strobe fall captures strobed_iack_n level.
// - Read/write select synchronised but ignored in acknowledge and all other cycles.
// - Wait mode: wait in acknowledge cycles only, not in register cycles.
// - Ready mode: ready asserted in acknowledge cycles only, never in reads.
// - Six types ranked: rx status, rx data, tx status, tx data, pin, misc.
// - Each type owns one enable, one pending and one under-service bit.
// - Request: pending, enable, no own or higher under-service, chain in, master enable.
// - Suppress vector: under-service still set, no vector driven.
// - Chain out high only with chain in high, no under-service, no block.
// - Muxed: strobed_iack_n low at address strobe rise freezes, starts.
`timescale 1ns/1ns
module iack_chain (
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Interrupt source events, one per type
  input  wire logic [iack_chain_pkg::NUM_TYPES-1:0] pend_set_i,
  // Host bus pins
  input  wire logic        strobed_iack_n_i,
  input  wire logic        pulsed_iack_n_i,
  input  wire logic        address_strobe_n_i,
  input  wire logic        data_strobe_n_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic        read_write_sel_i,
  input  wire logic        chain_enable_in_i,
  // Pin drivers
  output logic             chain_enable_out_o,
  output logic             int_req_n_o,
  output logic      [7:0]  addr_data_low_byte_o,
  output logic             addr_data_low_byte_oe_o,
  output logic             wait_or_ready_n_o,
  output logic             wait_or_ready_n_oe_o
);
  import iack_chain_pkg::*;

  localparam int NT = NUM_TYPES;
  localparam int NP = NUM_PINS;

  typedef struct packed {
    logic [NP-1:0] s1;
    logic [NP-1:0] s2;
    logic [NP-1:0] pv;
    logic [NT-1:0] ten;
    logic [NT-1:0] pend;
    logic [NT-1:0] under_service_bit;
    logic [NT-1:0] frz;
    logic          channel_master_int_enable;
    logic          nv;
    logic          block_lower_chain;
    logic          dps;
    logic          mux;
    logic          rdy_mode;
    logic [7:0]    vbase;
    ph_e           ph;
    logic          dp_second;
    logic          cap_iack;
    logic [7:0]    cnt;
    logic [7:0]    vec;
    logic          ad_oe;
    logic          wr_n;
    logic          wr_oe;
    logic          ceo;
    logic          irq_n;
    logic          ack;
    logic [31:0]   dat;
  } state_s;

  state_s st_q;
  state_s st_d;

  // Combinational helpers
  logic [NP-1:0] fall;
  logic [NP-1:0] rise;
  logic [NT-1:0] req_vec;
  logic [NT-1:0] hi_blk;
  logic [NT-1:0] top_one;
  logic [2:0]    top_idx;
  logic          requesting;
  logic          cei;
  logic          strobe_fall;
  logic          strobe_rise;
  logic          freeze_ev;
  logic          answer_ev;
  logic          end_ev;
  logic          hit;
  logic [31:0]   wmask;

  ////////////////////////////////////////////////////////////////////////
  // Edges and priority resolution
  always_comb begin
    fall = st_q.pv & ~st_q.s2;
    rise = ~st_q.pv & st_q.s2;
    cei  = st_q.s2[PIN_CEI];
    // A type is blocked by under-service of any higher type
    hi_blk[0] = 1'b0;
    for (int i = 1; i < NT; i++) begin
      hi_blk[i] = hi_blk[i-1] | st_q.under_service_bit[i-1];
    end
    for (int i = 0; i < NT; i++) begin
      req_vec[i] = st_q.pend[i] & st_q.ten[i] & ~st_q.under_service_bit[i]
                 & ~hi_blk[i] & cei & st_q.channel_master_int_enable;
    end
    requesting = |req_vec;
    // Highest requesting type among the frozen set
    top_one = '0;
    top_idx = 3'h0;
    for (int i = NT - 1; i >= 0; i--) begin
      if (st_q.frz[i]) begin
        top_one = '0;
        top_one[i] = 1'b1;
        top_idx = 3'(i);
      end
    end
    strobe_fall = fall[PIN_DS] | fall[PIN_RD];
    strobe_rise = (rise[PIN_DS] | rise[PIN_RD])
                & st_q.s2[PIN_DS] & st_q.s2[PIN_RD];
  end

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    st_d = st_q;
    freeze_ev = 1'b0;
    answer_ev = 1'b0;
    end_ev = 1'b0;
    wmask = '0;
    hit = 1'b0;

    // Two-stage pin synchronisers, edge history
    st_d.s1 = {chain_enable_in_i, read_write_sel_i, read_strobe_n_i,
               data_strobe_n_i, address_strobe_n_i, pulsed_iack_n_i,
               strobed_iack_n_i};
    st_d.s2 = st_q.s1;
    st_d.pv = st_q.s2;

    // Hardware sets pending; software clear below loses to it
    st_d.pend = st_q.pend;

    // Decode acknowledge events
    if (st_q.mux) begin
      if (rise[PIN_AS]) begin
        st_d.cap_iack = ~st_q.s2[PIN_SIACK];
        freeze_ev = ~st_q.s2[PIN_SIACK];
      end
      if (strobe_fall && st_q.cap_iack) begin
        answer_ev = 1'b1;
      end
    end else begin
      if (fall[PIN_SIACK]) begin
        freeze_ev = 1'b1;
      end
      if (strobe_fall) begin
        st_d.cap_iack = ~st_q.s2[PIN_SIACK];
        answer_ev = ~st_q.s2[PIN_SIACK];
      end
    end
    if (strobe_rise && st_q.ph != PH_FROZEN) begin
      end_ev = 1'b1;
    end
    // Pulsed acknowledge replaces the strobe
    if (fall[PIN_PIACK]) begin
      if (!st_q.dps) begin
        freeze_ev = 1'b1;
        answer_ev = 1'b1;
      end else if (!st_q.dp_second) begin
        freeze_ev = 1'b1;
        st_d.dp_second = 1'b1;
      end else begin
        answer_ev = 1'b1;
        st_d.dp_second = 1'b0;
      end
    end
    if (rise[PIN_PIACK] && st_q.ph != PH_FROZEN) begin
      end_ev = 1'b1;
    end

    // Acknowledge sequence
    case (st_q.ph)
      PH_IDLE: begin
        if (freeze_ev) begin
          st_d.frz = req_vec;
          st_d.ph = PH_FROZEN;
          if (answer_ev) begin
            st_d.ph = PH_IGNORE;
            if (cei && requesting) begin
              st_d.ph = PH_RESPOND;
            end
          end
        end
      end
      PH_FROZEN: begin
        if (answer_ev) begin
          // Chain in sampled at the answering edge
          if (cei && |st_q.frz) begin
            st_d.ph = PH_RESPOND;
          end else begin
            st_d.ph = PH_IGNORE;
          end
        end
      end
      PH_RESPOND: begin
        if (end_ev) begin
          st_d.ph = PH_IDLE;
        end
      end
      PH_IGNORE: begin
        if (end_ev) begin
          st_d.ph = PH_IDLE;
        end
      end
      default: st_d.ph = PH_IDLE;
    endcase

    // Entering the answer phase
    st_d.cnt = (st_q.cnt == 8'h00) ? 8'h00 : st_q.cnt - 8'h01;
    if (st_d.ph == PH_RESPOND && st_q.ph != PH_RESPOND) begin
      if (st_q.ph == PH_IDLE) begin
        st_d.frz = req_vec;
      end
      st_d.under_service_bit = st_q.under_service_bit | ((st_q.ph == PH_IDLE) ? top_vec(req_vec)
                                                  : top_one);
      st_d.vec = {st_q.vbase[7:3],
                  (st_q.ph == PH_IDLE) ? top_pos(req_vec) : top_idx};
      st_d.ad_oe = ~st_q.nv;
      st_d.cnt = st_q.rdy_mode ? 8'(IACK_RDY_CYC) : 8'(WAIT_HOLD_CYC);
    end
    if (st_d.ph != PH_RESPOND) begin
      st_d.ad_oe = 1'b0;
    end
    // Wait or ready pin; register cycles never raise wait
    if (st_q.ph == PH_RESPOND) begin
      st_d.wr_oe = 1'b1;
      if (st_q.rdy_mode) begin
        st_d.wr_n = (st_q.cnt > 8'h01);
      end else begin
        st_d.wr_n = (st_q.cnt <= 8'h01);
      end
    end else begin
      st_d.wr_oe = 1'b0;
      st_d.wr_n = 1'b1;
    end
    if (st_d.ph == PH_IDLE) begin
      st_d.frz = '0;
    end
    if (!st_q.dps) begin
      st_d.dp_second = 1'b0;
    end

    // Chain out from the next phase, so a single pulse blocks at once
    st_d.ceo = cei & ~(|st_d.under_service_bit) & ~st_q.block_lower_chain
             & ~((st_d.ph != PH_IDLE) & (|st_d.frz));
    st_d.irq_n = ~requesting;

    // Wishbone slave, ack one cycle on; writes land at the ack edge
    st_d.ack = cyc_i & stb_i & ~st_q.ack;
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{sel_i[b]}};
    end
    if (cyc_i && stb_i) begin
      hit = we_i & st_q.ack;
      st_d.dat = '0;
      case (adr_i)
        OFS_CTRL: begin
          st_d.dat = ctrl_word(st_q);
          if (hit) begin
            st_d.ten = (dat_i[CTRL_TEN_LSB +: NT] & wmask[NT-1:0])
                     | (st_q.ten & ~wmask[NT-1:0]);
            if (sel_i[1]) begin
              st_d.channel_master_int_enable = dat_i[CTRL_MIE];
              st_d.nv = dat_i[CTRL_NV];
              st_d.block_lower_chain = dat_i[CTRL_DLC];
              st_d.dps = dat_i[CTRL_DPULSE];
              st_d.mux = dat_i[CTRL_MUXED];
              st_d.rdy_mode = dat_i[CTRL_RDY_MODE];
            end
            if (sel_i[2]) begin
              st_d.vbase = dat_i[CTRL_VBASE_LSB +: 8];
            end
          end
        end
        OFS_STATUS: begin
          st_d.dat[STAT_PEND_LSB +: NT] = st_q.pend;
          st_d.dat[STAT_IUS_LSB +: NT] = st_q.under_service_bit;
          st_d.dat[STAT_DP_SECOND] = st_q.dp_second;
          st_d.dat[STAT_IACK_CY] = (st_q.ph != PH_IDLE);
        end
        OFS_PEND_CLR: begin
          if (hit && sel_i[0]) begin
            st_d.pend = st_q.pend & ~dat_i[NT-1:0];
          end
        end
        OFS_IUS_CLR: begin
          if (hit && sel_i[0]) begin
            st_d.under_service_bit = (st_q.under_service_bit & ~dat_i[NT-1:0]) | (st_d.under_service_bit & ~st_q.under_service_bit);
          end
        end
        OFS_PEND_SET: begin
          if (hit && sel_i[0]) begin
            st_d.pend = st_q.pend | dat_i[NT-1:0];
          end
        end
        default: st_d.dat = '0;
      endcase
    end
    // Set wins over a clear in the same cycle
    st_d.pend = st_d.pend | pend_set_i;
  end

  // Control register image
  function automatic logic [31:0] ctrl_word(input state_s s);
    logic [31:0] w;
    w = '0;
    w[CTRL_TEN_LSB +: NT] = s.ten;
    w[CTRL_MIE] = s.channel_master_int_enable;
    w[CTRL_NV] = s.nv;
    w[CTRL_DLC] = s.block_lower_chain;
    w[CTRL_DPULSE] = s.dps;
    w[CTRL_MUXED] = s.mux;
    w[CTRL_RDY_MODE] = s.rdy_mode;
    w[CTRL_VBASE_LSB +: 8] = s.vbase;
    return w;
  endfunction

  // One-hot of the lowest set bit position (index 0 first)
  function automatic logic [NT-1:0] top_vec(input logic [NT-1:0] v);
    logic [NT-1:0] r;
    r = '0;
    for (int i = NT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = '0;
        r[i] = 1'b1;
      end
    end
    return r;
  endfunction

  // Index of the highest-priority set bit
  function automatic logic [2:0] top_pos(input logic [NT-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NT - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.s1 <= '1;
      st_q.s2 <= '1;
      st_q.pv <= '1;
      st_q.vbase <= VBASE_RST;
      st_q.ph <= PH_IDLE;
      st_q.dp_second <= 1'b0;
      st_q.wr_n <= 1'b1;
      st_q.irq_n <= 1'b1;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign dat_o = st_q.dat;
  assign ack_o = st_q.ack;
  assign chain_enable_out_o = st_q.ceo;
  assign int_req_n_o = st_q.irq_n;
  assign addr_data_low_byte_o = st_q.vec;
  assign addr_data_low_byte_oe_o = st_q.ad_oe;
  assign wait_or_ready_n_o = st_q.wr_n;
  assign wait_or_ready_n_oe_o = st_q.wr_oe;

endmodule

/* File: iack_chain_monitor.sv */
// Concurrent checks on the acknowledge daisy-chain channel ports.
// Assumes full-word control writes; bound to every iack_chain.
`timescale 1ns/1ns
module iack_chain_monitor (
  // Clock, reset, bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  // Host pins
  input wire logic        pulsed_iack_n_i,
  input wire logic        data_strobe_n_i,
  input wire logic        read_strobe_n_i,
  input wire logic        chain_enable_in_i,
  // Pin drivers
  input wire logic        chain_enable_out_o,
  input wire logic [7:0]  addr_data_low_byte_o,
  input wire logic        addr_data_low_byte_oe_o,
  input wire logic        wait_or_ready_n_o,
  input wire logic        wait_or_ready_n_oe_o
);
  import iack_chain_pkg::*;
  logic [7:0] vbase_q;
  logic       nv_q, dlc_q, rdy_q;
  logic [2:0] idle_q;
  // Shadow control bits, count idle strobe cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {vbase_q, nv_q, dlc_q, rdy_q, idle_q} <= '0;
    end else begin
      if (cyc_i && stb_i && we_i && ack_o && adr_i == OFS_CTRL) begin
        {vbase_q, rdy_q} <= {dat_i[23:16], dat_i[CTRL_RDY_MODE]};
        {nv_q, dlc_q} <= {dat_i[CTRL_NV], dat_i[CTRL_DLC]};
      end
      if (!(pulsed_iack_n_i && data_strobe_n_i && read_strobe_n_i)) begin
        idle_q <= 3'h0;
      end else if (idle_q != 3'h7) begin
        idle_q <= idle_q + 3'h1;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////
  AST_WB_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered");
  AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_CHAIN_IN_LOW: assert property (
    !chain_enable_in_i [*3] |=> !chain_enable_out_o)
    else $error("chain out high with chain in low");
  AST_DLC_BLOCK: assert property (dlc_q [*3] |-> !chain_enable_out_o)
    else $error("chain out high while blocked");
  AST_FREEZE_CHAIN: assert property (
    $rose(addr_data_low_byte_oe_o) |-> !chain_enable_out_o)
    else $error("chain out high while answering");
  AST_VEC_CODE: assert property (addr_data_low_byte_oe_o |->
    addr_data_low_byte_o[7:3] == vbase_q[7:3]
    && addr_data_low_byte_o[2:0] < 3'h6)
    else $error("vector code wrong");
  AST_NV_QUIET: assert property (nv_q |-> !addr_data_low_byte_oe_o)
    else $error("vector driven while suppressed");
  AST_IDLE_RELEASE: assert property (idle_q == 3'h7 |->
    !wait_or_ready_n_oe_o && !addr_data_low_byte_oe_o)
    else $error("pins driven outside acknowledge");
  AST_WAIT_FAST: assert property (
    $rose(wait_or_ready_n_oe_o) && !rdy_q |-> ##[0:1] !wait_or_ready_n_o)
    else $error("wait not asserted");
  AST_RDY_LATE: assert property (
    $rose(wait_or_ready_n_oe_o) && rdy_q |->
    wait_or_ready_n_o [*3] ##[1:6] !wait_or_ready_n_o)
    else $error("ready timing wrong");
endmodule
bind iack_chain iack_chain_monitor i_iack_chain_monitor (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .ack_o,
  .pulsed_iack_n_i, .data_strobe_n_i, .read_strobe_n_i,
  .chain_enable_in_i, .chain_enable_out_o, .addr_data_low_byte_o,
  .addr_data_low_byte_oe_o, .wait_or_ready_n_o, .wait_or_ready_n_oe_o);

/* File: iack_host_model.sv */
// Host processor bus and upstream chain driving one channel's pins.
// Strobes idle high as with pull-ups; changes follow clk_i edges.
`timescale 1ns/1ns
module iack_host_model (
  // Clock and channel outputs
  input  wire logic       clk_i,
  input  wire logic [7:0] vec_i,
  input  wire logic       vec_oe_i,
  input  wire logic       wait_n_i,
  // Host strobes and chain
  output logic            strobed_iack_n_o,
  output logic            pulsed_iack_n_o,
  output logic            address_strobe_n_o,
  output logic            data_strobe_n_o,
  output logic            read_strobe_n_o,
  output logic            read_write_sel_o,
  output logic            chain_enable_in_o
);
  logic       seen, first_seen;
  logic [7:0] vec;
  int         cnt, t0, low_at;
  // Idle bus
  initial begin
    {strobed_iack_n_o, pulsed_iack_n_o, address_strobe_n_o} = 3'h7;
    {data_strobe_n_o, read_strobe_n_o, read_write_sel_o} = 3'h7;
    {chain_enable_in_o, seen, first_seen} = 3'h4;
  end
  // Take the vector and time the wait line
  task automatic watch(input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (vec_oe_i === 1'b1 && !seen) begin
        seen = 1'b1;
        vec = vec_i;
        t0 = cnt;
      end
      if (seen && wait_n_i === 1'b0 && low_at < 0) low_at = cnt - t0;
      cnt++;
    end
  endtask
  // Kinds: 0 strobed, 1 strobed muxed, 2 single pulse, 3 double pulse
  task automatic ack_cycle(input int kind, input logic cei);
    {seen, first_seen, low_at, cnt} = {2'h0, -32'sd1, 32'sd0};
    chain_enable_in_o <= cei;
    if (kind < 2) begin
      strobed_iack_n_o <= 1'b0;
      address_strobe_n_o <= (kind != 1);
      read_write_sel_o <= 1'b0;
      watch(6);
      address_strobe_n_o <= 1'b1;
      watch(6);
      if (kind == 1) read_strobe_n_o <= 1'b0;
      else data_strobe_n_o <= 1'b0;
      watch(14);
      {data_strobe_n_o, read_strobe_n_o} <= 2'h3;
      {strobed_iack_n_o, read_write_sel_o} <= 2'h3;
    end else begin
      if (kind == 3) begin
        pulsed_iack_n_o <= 1'b0;
        watch(6);
        pulsed_iack_n_o <= 1'b1;
        watch(6);
        first_seen = seen;
      end
      pulsed_iack_n_o <= 1'b0;
      watch(14);
      pulsed_iack_n_o <= 1'b1;
    end
    chain_enable_in_o <= 1'b1;
    watch(8);
  endtask
endmodule

/* File: iack_chain_bench.sv */
// Self-checking bench for the acknowledge daisy-chain channel.
// Pins come from iack_host_model; registers via Wishbone tasks.
`timescale 1ns/1ns
module iack_chain_bench;
  import iack_chain_pkg::*;
  localparam logic [7:0] VB = 8'hA8;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] dat, rdat;
  logic [5:0]  pend = 6'h00;
  logic        ack, ceo, ireq, vec_oe, wr_n, wr_oe;
  logic [7:0]  vec;
  logic        siack_n, piack_n, as_n, ds_n, rd_n, rw, cei;
  int          fail_count = 0;
  int          checked = 0;
  iack_chain i_iack_chain (
    .clk_i, .rst_i, .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat), .ack_o(ack),
    .pend_set_i(pend), .strobed_iack_n_i(siack_n),
    .pulsed_iack_n_i(piack_n), .address_strobe_n_i(as_n),
    .data_strobe_n_i(ds_n), .read_strobe_n_i(rd_n),
    .read_write_sel_i(rw), .chain_enable_in_i(cei),
    .chain_enable_out_o(ceo), .int_req_n_o(ireq),
    .addr_data_low_byte_o(vec), .addr_data_low_byte_oe_o(vec_oe),
    .wait_or_ready_n_o(wr_n), .wait_or_ready_n_oe_o(wr_oe));
  iack_host_model i_iack_host_model (
    .clk_i, .vec_i(vec), .vec_oe_i(vec_oe),
    .wait_n_i(wr_oe ? wr_n : 1'b1), .strobed_iack_n_o(siack_n),
    .pulsed_iack_n_o(piack_n), .address_strobe_n_o(as_n),
    .data_strobe_n_o(ds_n), .read_strobe_n_o(rd_n),
    .read_write_sel_o(rw), .chain_enable_in_o(cei));
  // Clock
  always #5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    sel <= (a == OFS_CTRL) ? 4'hF : 4'h1;
    @(posedge clk_i);
    // Only the watchdog ends a wait for ack
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rdat = dat;
    {cyc, stb} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    cmp_word(rdat, e);
  endtask
  task automatic pset(input logic [5:0] m);
    pend <= m;
    @(posedge clk_i);
    pend <= 6'h00;
    @(posedge clk_i);
  endtask
  task automatic clr();
    wr(OFS_PEND_CLR, 32'h0000_003F);
    wr(OFS_IUS_CLR, 32'h0000_003F);
  endtask
  // One acknowledge through the host, response checked
  task automatic iack(input int k, input logic c, input logic s,
                      input logic [7:0] v);
    i_iack_host_model.ack_cycle(k, c);
    cmp_bit(i_iack_host_model.seen, s);
    if (s) cmp_word({24'h00_0000, i_iack_host_model.vec}, {24'h00_0000, v});
  endtask
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rchk(OFS_CTRL, 32'h0000_0000);
    rchk(OFS_STATUS, 32'h0000_0000);
    rchk(8'h40, 32'h0000_0000);
    wr(OFS_CTRL, 32'h00A8_013F);
    rchk(OFS_CTRL, 32'h00A8_013F);
    pset(6'h14);
    rchk(OFS_STATUS, 32'h0000_0014);
    iack(0, 1'b1, 1'b1, {VB[7:3], TYPE_TX_STATUS});
    cmp_bit(i_iack_host_model.low_at inside {[0:2]}, 1'b1);
    rchk(OFS_STATUS, 32'h0000_0414);
    iack(0, 1'b1, 1'b0, 8'h00);
    wr(OFS_PEND_CLR, 32'h0000_0004);
    wr(OFS_IUS_CLR, 32'h0000_0004);
    wr(OFS_CTRL, 32'h00A8_113F);
    iack(1, 1'b1, 1'b1, {VB[7:3], TYPE_IO_PIN});
    rchk(OFS_STATUS, 32'h0000_1010);
    clr();
    wr(OFS_CTRL, 32'h00A8_013F);
    pset(6'h08);
    iack(0, 1'b0, 1'b0, 8'h00);
    rchk(OFS_STATUS, 32'h0000_0008);
    cmp_bit(ireq, 1'b0);
    cmp_bit(ceo, 1'b1);
    wr(OFS_CTRL, 32'h00A8_053F);
    repeat (4) @(posedge clk_i);
    cmp_bit(ceo, 1'b0);
    wr(OFS_CTRL, 32'h00A8_213F);
    iack(2, 1'b1, 1'b1, {VB[7:3], TYPE_TX_DATA});
    cmp_bit(i_iack_host_model.low_at inside {[4:8]}, 1'b1);
    clr();
    iack(2, 1'b1, 1'b0, 8'h00);
    wr(OFS_CTRL, 32'h00A8_093F);
    pset(6'h22);
    iack(3, 1'b1, 1'b1, {VB[7:3], TYPE_RX_DATA});
    cmp_bit(i_iack_host_model.first_seen, 1'b0);
    rchk(OFS_STATUS, 32'h0000_0222);
    wr(OFS_IUS_CLR, 32'h0000_003F);
    iack(3, 1'b0, 1'b0, 8'h00);
    rchk(OFS_STATUS, 32'h0000_0022);
    iack(3, 1'b1, 1'b1, {VB[7:3], TYPE_RX_DATA});
    wr(OFS_IUS_CLR, 32'h0000_003F);
    wr(OFS_CTRL, 32'h00A8_033F);
    iack(0, 1'b1, 1'b0, 8'h00);
    rchk(OFS_STATUS, 32'h0000_0222);
    wr(OFS_CTRL, 32'h00A8_003F);
    repeat (4) @(posedge clk_i);
    cmp_bit(ireq, 1'b1);
    end_sim();
  end
endmodule
